// ---- rtl/pmsp_pkg.sv ----
// Constants for the power monitor serial port: register map, field layout and timing.
// Assumes a 100 MHz system clock; every timing count is derived from that period.
// How it works
// - Two three-level address pins, each high, low or open, select one of nine target addresses.
// - Each incoming data bit is taken when the filtered serial clock rises.
// - The master keeps the serial clock at or below 400 kHz, which the sampling rate covers.
// - Serial clock or data held low for the stuck-bus time resets the serial state machine.
// - Pulses on serial clock or data shorter than the spike width are ignored.
// - Acknowledge and read data leave only on the separate open-drain data output pin.
// - The inverted-output variant pulls the data output pin low for a released bit.
// - Multi-function pins one and two are open-drain output, logic input or converter input.
// - Pin three as conversion-ready latches low or pulses low for 16 us or 128 us on new data.
// - Pin four as alert pulls low on faults whose alert enable bit is set.
// - Pins three and four also work as plain output, logic input or converter input.
// - Converters stay disabled while the internal low supply is below the 2.5 V lockout level.
// - Conversion-ready flags that new results exist and alert flags that a fault occurred.
package pmsp_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCL_MAX_KHZ = 400;
   localparam int SPIKE_MIN_NS = 50;
   localparam int SPIKE_CYC = (SPIKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STUCK_MIN_MS = 25;
   localparam int STUCK_CYC = (STUCK_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DR_SHORT_US = 16;
   localparam int DR_SHORT_CYC = DR_SHORT_US * 1000 / CLK_PERIOD_NS;
   localparam int DR_LONG_US = 128;
   localparam int DR_LONG_CYC = DR_LONG_US * 1000 / CLK_PERIOD_NS;
   localparam int UVLO_MV = 2500;
   localparam logic [6:0] ADDR_BASE = 7'h50;
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_STATUS = 5'h04;
   localparam logic [4:0] OFS_IRQ_STATUS = 5'h08;
   localparam logic [4:0] OFS_IRQ_ENABLE = 5'h0C;
   localparam logic [4:0] OFS_IRQ_CLEAR = 5'h10;
   localparam logic [4:0] OFS_LATCH_CLEAR = 5'h14;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam int CTRL_MODE_POS = 0;
   localparam int CTRL_DR_LONG_POS = 8;
   localparam int CTRL_DR_LATCH_POS = 9;
   localparam int CTRL_CONV_EN_POS = 10;
   localparam int CTRL_OUT_POS = 12;
   localparam int IRQ_W = 5;
   localparam int IRQ_START = 0;
   localparam int IRQ_STOP = 1;
   localparam int IRQ_STUCK = 2;
   localparam int IRQ_DATA = 3;
   localparam int IRQ_FAULT = 4;
   localparam logic [1:0] MODE_INPUT = 2'h0;
   localparam logic [1:0] MODE_OUTPUT = 2'h1;
   localparam logic [1:0] MODE_CONV = 2'h2;
   localparam logic [1:0] MODE_SPECIAL = 2'h3;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR_ACK = 3'b010,
      ST_WR = 3'b011,
      ST_WR_ACK = 3'b100,
      ST_RD = 3'b101,
      ST_RD_ACK = 3'b110,
      ST_WAIT = 3'b111
   } pmsp_state_t;
endpackage

// ---- rtl/pmsp_line_if.sv ----
// Carries one filtered serial line from its filter to the protocol logic.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface pmsp_line_if;
   logic level;
   logic rise;
   logic fall;
   modport filt (output level, output rise, output fall);
   modport user (input level, input rise, input fall);
endinterface
`default_nettype wire

// ---- rtl/pmsp_line_filter.sv ----
// Two-stage synchroniser and spike filter for one serial bus pin.
// Assumes the pin is asynchronous to clk; the rise and fall outputs are edge pulses one cycle wide.
`timescale 1ns/1ps
`default_nettype none
module pmsp_line_filter (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pin,
   pmsp_line_if.filt line
);
   logic meta_q;
   logic sync_q;
   logic level_q;
   logic rise_q;
   logic fall_q;
   logic [3:0] cnt_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
      end
   end

   // A new level is accepted only after it has held for the full spike width.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         level_q <= 1'b1;
         cnt_q <= 4'h0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         rise_q <= 1'b0;
         fall_q <= 1'b0;
         if (sync_q == level_q) begin
            cnt_q <= 4'h0;
         end else if (cnt_q == 4'(pmsp_pkg::SPIKE_CYC - 1)) begin
            cnt_q <= 4'h0;
            level_q <= sync_q;
            rise_q <= sync_q;
            fall_q <= ~sync_q;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end

   assign line.level = level_q;
   assign line.rise = rise_q;
   assign line.fall = fall_q;
endmodule
`default_nettype wire

// ---- rtl/pmsp_serial_port.sv ----
// Top of the power monitor serial port: two-wire target, multi-function pins and registers.
// Assumes Avalon-MM with waitrequest on clk; bus pins and strap comparators are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module pmsp_serial_port #(
   parameter bit INVERTED_OUT = 1'b0,
   parameter int STUCK_CYC = pmsp_pkg::STUCK_CYC,
   parameter int DR_SHORT_CYC = pmsp_pkg::DR_SHORT_CYC,
   parameter int DR_LONG_CYC = pmsp_pkg::DR_LONG_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   input wire logic scl_pin,
   input wire logic serial_data_in_pin,
   output logic serial_data_out_pin_o,
   output logic serial_data_out_pin_oe_n,
   input wire logic addr_select_hi_pin_h,
   input wire logic addr_select_hi_pin_l,
   input wire logic addr_select_lo_pin_h,
   input wire logic addr_select_lo_pin_l,
   input wire logic [3:0] multi_pin_i,
   output logic [3:0] multi_pin_o,
   output logic [3:0] multi_pin_oe_n,
   output logic conversion_ready_out,
   output logic [3:0] converter_input_sel,
   output logic converter_enable,
   input wire logic internal_low_supply_ok,
   input wire logic data_available,
   input wire logic [7:0] fault_events,
   input wire logic [7:0] alert_enable,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_command,
   input wire logic [7:0] tx_data,
   output logic tx_req,
   output logic target_active
);
   pmsp_line_if lines [2] ();
   logic [1:0] raw_pins;
   logic [5:0] asy_in;
   logic [5:0] asy_meta_q;
   logic [5:0] asy_q;
   logic [6:0] own_addr;
   logic scl_rise;
   logic scl_fall;
   logic scl_lvl;
   logic sda_lvl;
   logic sda_rise;
   logic sda_fall;
   logic start_det;
   logic stop_det;
   logic stuck_hit;
   logic [21:0] stuck_q;
   pmsp_pkg::pmsp_state_t state_q;
   logic [2:0] bit_q;
   logic [7:0] shift_q;
   logic first_q;
   logic sda_drive_q;
   logic [15:0] ctrl_q;
   logic [pmsp_pkg::IRQ_W-1:0] irq_stat_q;
   logic [pmsp_pkg::IRQ_W-1:0] irq_en_q;
   logic [pmsp_pkg::IRQ_W-1:0] irq_evt;
   logic ack_q;
   logic req;
   logic wr_en;
   logic dr_latch_q;
   logic [13:0] dr_cnt_q;
   logic alert_q;
   logic fault_hit;
   logic [1:0] pin_mode [4];

   // Maps the two threshold comparators of a strap pin to low, open or high.
   function automatic logic [1:0] tri_level(input logic above_hi, input logic above_lo);
      tri_level = above_hi ? 2'h2 : (above_lo ? 2'h1 : 2'h0);
   endfunction

   assign raw_pins = {serial_data_in_pin, scl_pin};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_line
         pmsp_line_filter u_filt (
            .clk(clk),
            .sys_rst(sys_rst),
            .pin(raw_pins[gi]),
            .line(lines[gi])
         );
      end
      for (gi = 0; gi < 4; gi++) begin : g_mode
         assign pin_mode[gi] = ctrl_q[pmsp_pkg::CTRL_MODE_POS + 2 * gi +: 2];
      end
   endgenerate

   assign scl_lvl = lines[0].level;
   assign scl_rise = lines[0].rise;
   assign scl_fall = lines[0].fall;
   assign sda_lvl = lines[1].level;
   assign sda_rise = lines[1].rise;
   assign sda_fall = lines[1].fall;
   assign start_det = sda_fall & scl_lvl;
   assign stop_det = sda_rise & scl_lvl;

   assign asy_in = {multi_pin_i, addr_select_lo_pin_h, addr_select_lo_pin_l};
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         asy_meta_q <= 6'h00;
         asy_q <= 6'h00;
      end else begin
         asy_meta_q <= asy_in;
         asy_q <= asy_meta_q;
      end
   end

   logic [1:0] hi_meta_q;
   logic [1:0] hi_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hi_meta_q <= 2'h0;
         hi_q <= 2'h0;
      end else begin
         hi_meta_q <= {addr_select_hi_pin_h, addr_select_hi_pin_l};
         hi_q <= hi_meta_q;
      end
   end

   // Nine strap settings give nine consecutive addresses starting at the base.
   assign own_addr = pmsp_pkg::ADDR_BASE + 7'(3 * tri_level(hi_q[1], hi_q[0]))
                     + 7'(tri_level(asy_q[1], asy_q[0]));

   // Either line held low too long frees a master that lost the bus mid-frame.
   always_ff @(posedge clk) begin
      if (sys_rst || (scl_lvl && sda_lvl) || stuck_hit) begin
         stuck_q <= 22'h000000;
      end else begin
         stuck_q <= stuck_q + 22'h000001;
      end
   end
   assign stuck_hit = (stuck_q == 22'(STUCK_CYC - 1));

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= pmsp_pkg::ST_IDLE;
         bit_q <= 3'h0;
         shift_q <= 8'h00;
         first_q <= 1'b0;
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
         rx_command <= 1'b0;
         tx_req <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         tx_req <= 1'b0;
         if (stuck_hit || stop_det) begin
            state_q <= pmsp_pkg::ST_IDLE;
         end else if (start_det) begin
            state_q <= pmsp_pkg::ST_ADDR;
            bit_q <= 3'h0;
         end else if (scl_rise) begin
            case (state_q)
               pmsp_pkg::ST_ADDR: begin
                  shift_q <= {shift_q[6:0], sda_lvl};
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     if (shift_q[6:0] == own_addr) begin
                        state_q <= pmsp_pkg::ST_ADDR_ACK;
                        first_q <= 1'b1;
                        if (sda_lvl) begin
                           tx_req <= 1'b1;
                        end
                     end else begin
                        state_q <= pmsp_pkg::ST_WAIT;
                     end
                  end
               end
               pmsp_pkg::ST_ADDR_ACK: begin
                  state_q <= shift_q[0] ? pmsp_pkg::ST_RD : pmsp_pkg::ST_WR;
                  if (shift_q[0]) begin
                     shift_q <= tx_data;
                  end
               end
               pmsp_pkg::ST_WR: begin
                  shift_q <= {shift_q[6:0], sda_lvl};
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     state_q <= pmsp_pkg::ST_WR_ACK;
                     rx_data <= {shift_q[6:0], sda_lvl};
                     rx_valid <= 1'b1;
                     rx_command <= first_q;
                     first_q <= 1'b0;
                  end
               end
               pmsp_pkg::ST_WR_ACK: begin
                  state_q <= pmsp_pkg::ST_WR;
               end
               pmsp_pkg::ST_RD: begin
                  shift_q <= {shift_q[6:0], 1'b0};
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     state_q <= pmsp_pkg::ST_RD_ACK;
                  end
               end
               pmsp_pkg::ST_RD_ACK: begin
                  // A master nack ends the read; the bus is then left alone until the next start or stop.
                  if (sda_lvl) begin
                     state_q <= pmsp_pkg::ST_WAIT;
                  end else begin
                     state_q <= pmsp_pkg::ST_RD;
                     shift_q <= tx_data;
                     tx_req <= 1'b1;
                  end
               end
               default: begin
                  state_q <= state_q;
               end
            endcase
         end
      end
   end

   // The data output changes only after the clock falls, so hold time on the bus is met.
   always_ff @(posedge clk) begin
      if (sys_rst || stuck_hit || stop_det || start_det) begin
         sda_drive_q <= 1'b0;
      end else if (scl_fall) begin
         case (state_q)
            pmsp_pkg::ST_ADDR_ACK: sda_drive_q <= 1'b1;
            pmsp_pkg::ST_WR_ACK: sda_drive_q <= 1'b1;
            pmsp_pkg::ST_RD: sda_drive_q <= ~shift_q[7];
            default: sda_drive_q <= 1'b0;
         endcase
      end
   end

   assign serial_data_out_pin_o = 1'b0;
   assign serial_data_out_pin_oe_n = INVERTED_OUT ? sda_drive_q : ~sda_drive_q;
   assign target_active = (state_q != pmsp_pkg::ST_IDLE) && (state_q != pmsp_pkg::ST_WAIT);

   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   assign wr_en = avs_write & ack_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= pmsp_pkg::CTRL_RESET;
         irq_en_q <= '0;
      end else if (wr_en) begin
         if (avs_address == pmsp_pkg::OFS_CTRL) begin
            ctrl_q <= avs_writedata[15:0];
         end
         if (avs_address == pmsp_pkg::OFS_IRQ_ENABLE) begin
            irq_en_q <= avs_writedata[pmsp_pkg::IRQ_W-1:0];
         end
      end
   end

   // Read data is loaded while waitrequest is high and stands at the accepting edge.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !ack_q) begin
         case (avs_address)
            pmsp_pkg::OFS_CTRL: avs_readdata <= {16'h0000, ctrl_q};
            pmsp_pkg::OFS_STATUS: avs_readdata <= {17'h00000, internal_low_supply_ok,
               alert_q, conversion_ready_out, target_active, own_addr, asy_q[5:2]};
            pmsp_pkg::OFS_IRQ_STATUS: avs_readdata <= {27'h0000000, irq_stat_q};
            pmsp_pkg::OFS_IRQ_ENABLE: avs_readdata <= {27'h0000000, irq_en_q};
            default: avs_readdata <= 32'h00000000;
         endcase
      end
   end

   assign fault_hit = |(fault_events & alert_enable);
   assign irq_evt = {fault_hit, data_available, stuck_hit, stop_det, start_det};
   // A new event in the clearing cycle survives the clear.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_stat_q <= '0;
      end else if (wr_en && avs_address == pmsp_pkg::OFS_IRQ_CLEAR) begin
         irq_stat_q <= (irq_stat_q & ~avs_writedata[pmsp_pkg::IRQ_W-1:0]) | irq_evt;
      end else begin
         irq_stat_q <= irq_stat_q | irq_evt;
      end
   end
   assign irq = |(irq_stat_q & irq_en_q);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dr_latch_q <= 1'b0;
         dr_cnt_q <= 14'h0000;
      end else begin
         if (data_available && ctrl_q[pmsp_pkg::CTRL_DR_LATCH_POS]) begin
            dr_latch_q <= 1'b1;
         end else if (wr_en && avs_address == pmsp_pkg::OFS_LATCH_CLEAR && avs_writedata[0]) begin
            dr_latch_q <= 1'b0;
         end
         if (data_available && !ctrl_q[pmsp_pkg::CTRL_DR_LATCH_POS]) begin
            dr_cnt_q <= ctrl_q[pmsp_pkg::CTRL_DR_LONG_POS] ? 14'(DR_LONG_CYC)
                        : 14'(DR_SHORT_CYC);
         end else if (dr_cnt_q != 14'h0000) begin
            dr_cnt_q <= dr_cnt_q - 14'h0001;
         end
      end
   end
   assign conversion_ready_out = dr_latch_q | (dr_cnt_q != 14'h0000);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         alert_q <= 1'b0;
      end else if (fault_hit) begin
         alert_q <= 1'b1;
      end else if (wr_en && avs_address == pmsp_pkg::OFS_LATCH_CLEAR && avs_writedata[1]) begin
         alert_q <= 1'b0;
      end
   end

   // Pins are open drain: a pin in input or converter mode is simply released.
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pin
         logic pull_low;
         always_comb begin
            case (pin_mode[gi])
               pmsp_pkg::MODE_OUTPUT: pull_low = ~ctrl_q[pmsp_pkg::CTRL_OUT_POS + gi];
               pmsp_pkg::MODE_SPECIAL: begin
                  if (gi == 2) begin
                     pull_low = conversion_ready_out;
                  end else if (gi == 3) begin
                     pull_low = alert_q;
                  end else begin
                     pull_low = 1'b0;
                  end
               end
               default: pull_low = 1'b0;
            endcase
         end
         assign multi_pin_o[gi] = 1'b0;
         assign multi_pin_oe_n[gi] = ~pull_low;
         assign converter_input_sel[gi] = (pin_mode[gi] == pmsp_pkg::MODE_CONV);
      end
   endgenerate

   assign converter_enable = ctrl_q[pmsp_pkg::CTRL_CONV_EN_POS] & internal_low_supply_ok;
endmodule
`default_nettype wire

// ---- verif/pmsp_serial_port_monitor.sv ----
// Port-level checks on the serial port top.
// Assumes it is bound to pmsp_serial_port built with the non-inverted data output.
`timescale 1ns/1ps
`default_nettype none
module pmsp_serial_port_monitor #(
   parameter int STUCK_CYC = 200
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic avs_write,
   input wire logic scl_pin,
   input wire logic serial_data_out_pin_o,
   input wire logic serial_data_out_pin_oe_n,
   input wire logic [3:0] multi_pin_o,
   input wire logic [3:0] multi_pin_oe_n,
   input wire logic conversion_ready_out,
   input wire logic converter_enable,
   input wire logic internal_low_supply_ok,
   input wire logic data_available,
   input wire logic [7:0] fault_events,
   input wire logic [7:0] alert_enable,
   input wire logic rx_valid,
   input wire logic target_active
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [31:0] low_q;
   logic [7:0] armed;
   assign armed = fault_events & alert_enable;
   // No saturation: a run never comes near a wrap of this count.
   always_ff @(posedge clk) begin
      if (sys_rst || scl_pin) begin
         low_q <= 32'h0;
      end else begin
         low_q <= low_q + 32'h1;
      end
   end
   property p_od; serial_data_out_pin_o == 1'b0 && multi_pin_o == 4'h0; endproperty
   a_od: assert property (p_od) else $error("open-drain pin driven high");
   property p_uvlo; !internal_low_supply_ok |-> !converter_enable; endproperty
   a_uvlo: assert property (p_uvlo) else $error("converter on in lockout");
   property p_rdy; $rose(conversion_ready_out) |->
      $past(data_available) || $past(data_available, 2); endproperty
   a_rdy: assert property (p_rdy) else $error("ready without new data");
   property p_alert; $fell(multi_pin_oe_n[3]) && !$past(avs_write) && !$past(avs_write, 2)
      |-> $past(armed) != 8'h00 || $past(armed, 2) != 8'h00; endproperty
   a_alert: assert property (p_alert) else $error("alert without enabled fault");
   property p_stuck; low_q > 32'(STUCK_CYC + 16) |-> !target_active; endproperty
   a_stuck: assert property (p_stuck) else $error("transfer survives stuck clock");
   property p_rx; rx_valid |-> target_active; endproperty
   a_rx: assert property (p_rx) else $error("byte outside a transfer");
   property p_rise; rx_valid |-> scl_pin && $past(scl_pin, 4); endproperty
   a_rise: assert property (p_rise) else $error("byte not on clock rise");
   property p_spk; $changed(serial_data_out_pin_oe_n) |->
      !$past(scl_pin) && !$past(scl_pin, 5); endproperty
   a_spk: assert property (p_spk) else $error("data out moved in clock high");
   c_rdy: cover property ($rose(conversion_ready_out));
   c_alert: cover property ($fell(multi_pin_oe_n[3]));
   c_rx: cover property (rx_valid);
endmodule
`default_nettype wire

// ---- verif/pmsp_host_model.sv ----
// Behavioural two-wire bus master driving clock and data open-drain.
// Assumes pull-ups on both lines; sda_line is the resolved data wire.
`timescale 1ns/1ps
`default_nettype none
module pmsp_host_model #(
   parameter int HALF = 1300
) (
   output logic scl,
   output logic sda,
   input wire logic sda_line
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Data moves an eighth of a period (HALF / 4) after the fall so it never races the filtered clock.
   task automatic bit_io(input logic b, input bit spike, output logic r);
      #(HALF / 4);
      sda = b;
      #(HALF / 4);
      if (spike) begin
         scl = 1'b1;
         #30;
         scl = 1'b0;
      end
      #(HALF / 2);
      scl = 1'b1;
      #(HALF / 2);
      r = sda_line;
      #(HALF / 2);
      scl = 1'b0;
   endtask
   task automatic start;
      sda = 1'b1;
      scl = 1'b1;
      #HALF;
      sda = 1'b0;
      #HALF;
      scl = 1'b0;
   endtask
   task automatic stop;
      #(HALF / 4);
      sda = 1'b0;
      #HALF;
      scl = 1'b1;
      #HALF;
      sda = 1'b1;
      #HALF;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ai, input bit sp, output logic [7:0] q,
                       output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], sp && i == 4, q[i]);
      end
      bit_io(ai, 1'b0, ack);
   endtask
endmodule
`default_nettype wire

// ---- verif/pmsp_serial_port_bench.sv ----
// Self-checking bench for the serial port top, with a bus-master model on the wire.
// Assumes the package, line interface, design, monitor and host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pmsp_serial_port_bench;
   localparam int STUCK = 5000;
   logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, data_available = 1'b0;
   logic hh = 1'b0, hl = 1'b0, lh = 1'b0, ll = 1'b0, supply_ok = 1'b0, cmd_flag = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic avs_waitrequest, irq, scl_pin, sda_host, sda_line, sdo, sdo_oe_n, ready, conv_en;
   logic rx_valid, rx_command, tx_req, target_active, ack;
   logic [3:0] pins_in = 4'h0, mo, moe, csel;
   logic [7:0] fault_events = 8'h00, alert_enable = 8'h00, tx_data = 8'h00, rx_data, v, b;
   logic [7:0] exp_q[$];
   int errors = 0, n_checks = 0, cyc = 0, n, n_tx = 0;
   always #5 clk = ~clk;
   assign sda_line = sda_host & (sdo_oe_n | sdo);
   pmsp_host_model host (.scl(scl_pin), .sda(sda_host), .sda_line(sda_line));
   pmsp_serial_port #(.STUCK_CYC(STUCK), .DR_SHORT_CYC(16), .DR_LONG_CYC(64)) uut (
      .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .scl_pin(scl_pin),
      .serial_data_in_pin(sda_line), .serial_data_out_pin_o(sdo),
      .serial_data_out_pin_oe_n(sdo_oe_n), .addr_select_hi_pin_h(hh),
      .addr_select_hi_pin_l(hl), .addr_select_lo_pin_h(lh), .addr_select_lo_pin_l(ll),
      .multi_pin_i(pins_in), .multi_pin_o(mo), .multi_pin_oe_n(moe),
      .conversion_ready_out(ready), .converter_input_sel(csel), .converter_enable(conv_en),
      .internal_low_supply_ok(supply_ok), .data_available(data_available),
      .fault_events(fault_events), .alert_enable(alert_enable), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_command(rx_command), .tx_data(tx_data), .tx_req(tx_req),
      .target_active(target_active));
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // The request stands until waitrequest is seen low, so a slow answer is never cut short.
   task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic ev(input logic da, input logic [7:0] f);
      @(posedge clk);
      data_available <= da;
      fault_events <= f;
      @(posedge clk);
      data_available <= 1'b0;
      fault_events <= 8'h00;
      n = 0;
      repeat (100) begin
         @(posedge clk);
         n += (ready === 1'b1) ? 1 : 0;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         errors++;
         wrap_up();
      end
   end
   always @(posedge clk) begin
      n_tx += (tx_req === 1'b1) ? 1 : 0;
      if (rx_valid === 1'b1) begin
         chk({rx_command, rx_data}, {cmd_flag, exp_q.pop_front()});
         cmd_flag = 1'b0;
      end
   end
   initial begin
      void'($urandom(3));
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         {hh, hl} <= {i >= 6, i >= 3};
         {lh, ll} <= {i % 3 == 2, i % 3 != 0};
         repeat (4) @(posedge clk);
         av(1'b0, pmsp_pkg::OFS_STATUS, 32'h0);
         chk(32'(q[10:4]), 32'(pmsp_pkg::ADDR_BASE) + 32'(i));
      end
      v = 8'($urandom);
      exp_q.push_back(v);
      exp_q.push_back(~v);
      cmd_flag = 1'b1;
      host.start();
      host.xfer(8'hB0, 1'b1, 1'b0, b, ack);
      chk(ack, 1'b0);
      host.xfer(v, 1'b1, 1'b1, b, ack);
      host.xfer(~v, 1'b1, 1'b0, b, ack);
      host.stop();
      chk(exp_q.size(), 0);
      av(1'b0, pmsp_pkg::OFS_IRQ_STATUS, 32'h0);
      chk(q, 32'h3);
      av(1'b1, pmsp_pkg::OFS_IRQ_ENABLE, 32'h2);
      @(posedge clk);
      chk(irq, 1'b1);
      av(1'b1, pmsp_pkg::OFS_IRQ_CLEAR, 32'h2);
      av(1'b0, pmsp_pkg::OFS_IRQ_STATUS, 32'h0);
      chk({irq, q[4:0]}, 6'h01);
      v = 8'($urandom);
      tx_data <= v;
      host.start();
      host.xfer(8'hB1, 1'b1, 1'b0, b, ack);
      host.xfer(8'hFF, 1'b1, 1'b0, b, ack);
      chk(b, v);
      chk(n_tx, 1);
      host.stop();
      host.start();
      host.xfer(8'hB0, 1'b1, 1'b0, b, ack);
      #((STUCK + 40) * 10);
      chk(target_active, 1'b0);
      host.stop();
      av(1'b0, pmsp_pkg::OFS_IRQ_STATUS, 32'h0);
      chk(q[2], 1'b1);
      pins_in <= v[3:0];
      av(1'b1, pmsp_pkg::OFS_CTRL, {16'h0, v[7:4], 12'h055});
      @(posedge clk);
      chk(moe, v[7:4]);
      av(1'b0, pmsp_pkg::OFS_STATUS, 32'h0);
      chk(q[3:0], v[3:0]);
      av(1'b1, pmsp_pkg::OFS_CTRL, 32'hAA);
      @(posedge clk);
      chk({csel, moe}, 8'hFF);
      for (int m = 0; m < 3; m++) begin
         av(1'b1, pmsp_pkg::OFS_CTRL, 32'h30 | (32'h100 * 32'(m)));
         ev(1'b1, 8'h00);
         chk(m == 2 ? 32'(ready) : n, m == 2 ? 1 : (m == 1 ? 64 : 16));
      end
      av(1'b1, pmsp_pkg::OFS_LATCH_CLEAR, 32'h1);
      @(posedge clk);
      chk({ready, moe[2]}, 2'b01);
      alert_enable <= 8'h01;
      av(1'b1, pmsp_pkg::OFS_CTRL, 32'hC0);
      ev(1'b0, 8'h02);
      chk(moe[3], 1'b1);
      ev(1'b0, 8'h01);
      chk(moe[3], 1'b0);
      av(1'b1, pmsp_pkg::OFS_LATCH_CLEAR, 32'h2);
      @(posedge clk);
      chk(moe[3], 1'b1);
      av(1'b1, pmsp_pkg::OFS_CTRL, 32'h400);
      @(posedge clk);
      chk(conv_en, 1'b0);
      supply_ok <= 1'b1;
      repeat (2) @(posedge clk);
      chk(conv_en, 1'b1);
      wrap_up();
   end
endmodule
bind pmsp_serial_port pmsp_serial_port_monitor #(.STUCK_CYC(STUCK_CYC)) mon (
   .clk(clk), .sys_rst(sys_rst), .avs_write(avs_write), .scl_pin(scl_pin),
   .serial_data_out_pin_o(serial_data_out_pin_o),
   .serial_data_out_pin_oe_n(serial_data_out_pin_oe_n), .multi_pin_o(multi_pin_o),
   .multi_pin_oe_n(multi_pin_oe_n), .conversion_ready_out(conversion_ready_out),
   .converter_enable(converter_enable), .internal_low_supply_ok(internal_low_supply_ok),
   .data_available(data_available), .fault_events(fault_events),
   .alert_enable(alert_enable), .rx_valid(rx_valid), .target_active(target_active));
`default_nettype wire
